// ===== vcm_pkg.sv
// Functional notes
// - J2 byte becomes the accepted trace identifier
// - BIP-2 over previous frame flags near errors
// - V5 bit 3 counts one far error
// - V5 bit 8 high means remote defect
// - K4 bits 5 to 8 are ignored
// - V5 bits 5-7 feed unequipped detection
// - defects other than degrade cleared by server fail or AIS
// - trace mismatch detection can be disabled
// - AIS set after five frames of 111
// - AIS cleared after five non-111 frames
// - trail fail and degrade consequent actions
// - unequipped report needs zero accepted trace
// - mismatch report unless unequipped with zero trace
// - degrade report only without trace mismatch
// - remote defect report with all qualifiers
// - server fail report from SSF or AIS
// - defect seconds and errored block sums
package vcm_pkg;

    // frame layout: byte 0 is V5, flagged by frame start
    localparam int unsigned FRAME_BYTES_DEF = 428;
    localparam int unsigned J2_POS          = 107;

    // V5 bit positions, bit 1 of the byte is the msb
    localparam int unsigned V5_BIP_HI = 7;
    localparam int unsigned V5_BIP_LO = 6;
    localparam int unsigned V5_REI    = 5;
    localparam int unsigned V5_PSL_HI = 3;
    localparam int unsigned V5_PSL_LO = 1;
    localparam int unsigned V5_RDI    = 0;

    // signal label codes
    localparam logic [2:0] PSL_UNEQ = 3'h0;
    localparam logic [2:0] PSL_AIS  = 3'h7;

    // persistence counts in frames
    localparam int unsigned AIS_FRAMES   = 5;
    localparam int unsigned UNEQ_FRAMES  = 5;
    localparam int unsigned RDI_FRAMES   = 5;
    localparam int unsigned TRACE_FRAMES = 3;

    // reset values and mode codes
    localparam logic [7:0] TRACE_RESET = 8'h00;
    localparam logic [7:0] TRACE_ZERO  = 8'h00;
    localparam logic       TPM_MON     = 1'b1;

    localparam int unsigned PM_CNT_W = 16;
    localparam int unsigned DEGRADE_WINDOW_COUNT_W   = 4;

    // correlated fault reports
    typedef struct packed {
        logic unequipped;
        logic trace_mismatch;
        logic degraded;
        logic remote_defect;
        logic server_fail;
    } vcm_report_s;

    // one-second performance figures
    typedef struct packed {
        logic                near_defect_second;
        logic                far_defect_second;
        logic [PM_CNT_W-1:0] near_errored_block_count;
        logic [PM_CNT_W-1:0] far_errored_block_count;
    } vcm_pm_s;

    // incoming path signals, sampled together
    typedef struct packed {
        logic       clk;
        logic       fs;
        logic       ssf;
        logic [7:0] data;
    } vcm_link_s;

endpackage

// ===== vcm_persist.sv
`timescale 1ns/1ps
// consecutive-sample filter: state flips after n samples that disagree with it
module vcm_persist #(
    parameter int unsigned N = 5
) (
    input  wire logic sys_clk_i,
    input  wire logic reset_n_i,
    input  wire logic sample_i,
    input  wire logic level_i,
    input  wire logic clear_i,
    output logic      state_o
);
    localparam int unsigned CW = $clog2(N + 1);
    localparam logic [CW-1:0] LAST = CW'(N - 1);

    logic [CW-1:0] run_q;

    initial begin
        if (N < 1) begin
            $error("vcm_persist: N must be at least 1");
        end
    end

    // a matching sample restarts the run, so the count is truly consecutive
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i || clear_i) begin
            run_q   <= '0;
            state_o <= 1'b0;
        end else if (sample_i) begin
            if (level_i == state_o) begin
                run_q <= '0;
            end else if (run_q == LAST) begin
                run_q   <= '0;
                state_o <= level_i;
            end else begin
                run_q <= run_q + 1'b1;
            end
        end
    end
endmodule

// ===== vcm_path_monitor.sv
`timescale 1ns/1ps
// non-intrusive VC-2 path monitor, byte-wide path input with its own clock
module vcm_path_monitor
    import vcm_pkg::*;
#(
    parameter int unsigned FRAME_BYTES = FRAME_BYTES_DEF
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  ci_clk_i,
    input  wire logic [7:0]            ci_data_i,
    input  wire logic                  ci_fs_i,
    input  wire logic                  incoming_server_signal_fail_i,
    input  wire logic                  termination_point_mode_i,
    input  wire logic                  server_fail_report_enable_i,
    input  wire logic                  remote_defect_report_enable_i,
    input  wire logic [7:0]            expected_trace_id_i,
    input  wire logic                  expected_trace_compare_mode_i,
    input  wire logic                  trace_mismatch_disable_i,
    input  wire logic [PM_CNT_W-1:0]   degrade_threshold_i,
    input  wire logic [DEGRADE_WINDOW_COUNT_W-1:0]     degrade_window_count_i,
    input  wire logic                  one_second_tick_i,
    input  wire logic                  equipment_defect_i,
    output logic                       trail_signal_fail_action_o,
    output logic                       trail_signal_degrade_action_o,
    output vcm_pkg::vcm_report_s       report_o,
    output logic [7:0]                 accepted_trace_id_o,
    output vcm_pkg::vcm_pm_s           pm_o,
    output logic                       pm_valid_o,
    output logic                       near_block_error_o,
    output logic                       far_block_error_o
);
    import vcm_pkg::*;

    localparam int unsigned PW = $clog2(FRAME_BYTES);
    localparam logic [PW-1:0] POS_LAST = PW'(FRAME_BYTES - 1);
    localparam logic [PW-1:0] POS_J2   = PW'(J2_POS);

    initial begin
        if (FRAME_BYTES <= J2_POS + 1) begin
            $error("vcm_path_monitor: FRAME_BYTES too small for the J2 position");
        end
    end

    // saturating increment, shared by the counters
    function automatic logic [PM_CNT_W-1:0] sat_inc(input logic [PM_CNT_W-1:0] v);
        sat_inc = (&v) ? v : v + 1'b1;
    endfunction

    vcm_link_s link_raw;
    vcm_link_s link_s1_q;
    vcm_link_s link_s2_q;
    vcm_link_s link_s3_q;
    vcm_link_s link_q;
    vcm_link_s link_d;
    vcm_link_s agree;

    assign link_raw = '{clk: ci_clk_i, fs: ci_fs_i, ssf: incoming_server_signal_fail_i,
                        data: ci_data_i};

    // three-stage capture of everything arriving from the path side
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            link_s1_q <= '0;
            link_s2_q <= '0;
            link_s3_q <= '0;
        end else begin
            link_s1_q <= link_raw;
            link_s2_q <= link_s1_q;
            link_s3_q <= link_s2_q;
        end
    end

    // a bit changes only once stages two and three agree, filtering glitches
    assign agree  = ~(link_s2_q ^ link_s3_q);
    assign link_d = (link_s3_q & agree) | (link_q & ~agree);

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            link_q <= '0;
        end else begin
            link_q <= link_d;
        end
    end

    logic       byte_stb;
    logic       v5_stb;
    logic [7:0] byte_val;

    // the path clock rising edge takes one byte; data is settled by then
    assign byte_stb = link_d.clk & ~link_q.clk;
    assign byte_val = link_d.data;
    assign v5_stb   = byte_stb & link_d.fs;

    logic [PW-1:0] pos_q;
    logic          in_frame_q;
    logic          prev_full_q;
    logic          j2_stb;

    // byte position within the frame; the frame after a short one is not trusted for parity
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            pos_q       <= '0;
            in_frame_q  <= 1'b0;
            prev_full_q <= 1'b0;
        end else if (v5_stb) begin
            prev_full_q <= in_frame_q && (pos_q == POS_LAST);
            pos_q       <= '0;
            in_frame_q  <= 1'b1;
        end else if (byte_stb && in_frame_q && pos_q != POS_LAST) begin
            pos_q <= pos_q + 1'b1;
        end
    end

    // K4 and every other byte carry no meaning here and are never decoded
    assign j2_stb = byte_stb & ~link_d.fs & in_frame_q & (pos_q + 1'b1 == POS_J2);

    logic [1:0] bip_q;
    logic [1:0] bip_byte;
    logic       near_err;
    logic       far_err;
    logic       server_fail_condition;
    logic       alarm_indication_defect;

    // odd bits feed BIP bit 1, even bits feed BIP bit 2
    assign bip_byte = {byte_val[7] ^ byte_val[5] ^ byte_val[3] ^ byte_val[1],
                       byte_val[6] ^ byte_val[4] ^ byte_val[2] ^ byte_val[0]};

    // parity restarts on V5 so the V5 byte itself is covered
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            bip_q <= 2'h0;
        end else if (v5_stb) begin
            bip_q <= bip_byte;
        end else if (byte_stb) begin
            bip_q <= bip_q ^ bip_byte;
        end
    end

    // errors are not counted while the server signal has failed
    assign near_err = v5_stb & prev_full_q & ~server_fail_condition &
                      (byte_val[V5_BIP_HI:V5_BIP_LO] != bip_q);
    assign far_err  = v5_stb & ~server_fail_condition & byte_val[V5_REI];

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            near_block_error_o <= 1'b0;
            far_block_error_o  <= 1'b0;
        end else begin
            near_block_error_o <= near_err;
            far_block_error_o  <= far_err;
        end
    end

    logic [2:0] psl;
    logic       unequipped_defect;
    logic       remote_defect;

    assign psl = byte_val[V5_PSL_HI:V5_PSL_LO];
    // AIS counts the SSF as its own clear, the others also clear on AIS
    assign server_fail_condition = link_q.ssf | alarm_indication_defect;

    // five consecutive frames set and clear AIS
    vcm_persist #(
        .N (AIS_FRAMES)
    ) u_ais (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .sample_i  (v5_stb),
        .level_i   (psl == PSL_AIS),
        .clear_i   (link_q.ssf),
        .state_o   (alarm_indication_defect)
    );

    // unequipped label detection
    vcm_persist #(
        .N (UNEQ_FRAMES)
    ) u_uneq (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .sample_i  (v5_stb),
        .level_i   (psl == PSL_UNEQ),
        .clear_i   (server_fail_condition),
        .state_o   (unequipped_defect)
    );

    // V5 bit 8 at one is a remote defect
    vcm_persist #(
        .N (RDI_FRAMES)
    ) u_rdi (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .sample_i  (v5_stb),
        .level_i   (byte_val[V5_RDI]),
        .clear_i   (server_fail_condition),
        .state_o   (remote_defect)
    );

    logic [7:0] received_trace_id;
    logic [7:0] trace_cand_q;
    logic [1:0] trace_run_q;
    logic [7:0] accepted_trace_id_q;

    assign received_trace_id = byte_val;

    // a trace is accepted after three identical J2 bytes in a row
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            trace_cand_q        <= TRACE_RESET;
            trace_run_q         <= 2'h0;
            accepted_trace_id_q <= TRACE_RESET;
        end else if (j2_stb && !server_fail_condition) begin
            if (received_trace_id != trace_cand_q || trace_run_q == 2'h0) begin
                trace_cand_q <= received_trace_id;
                trace_run_q  <= 2'h1;
            end else if (trace_run_q == 2'(TRACE_FRAMES - 1)) begin
                accepted_trace_id_q <= received_trace_id;
            end else begin
                trace_run_q <= trace_run_q + 1'b1;
            end
        end
    end

    logic trace_mismatch_defect_q;

    // mismatch is judged only when comparison is on and not disabled
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            trace_mismatch_defect_q <= 1'b0;
        end else begin
            trace_mismatch_defect_q <= expected_trace_compare_mode_i &&
                                       !trace_mismatch_disable_i &&
                                       !server_fail_condition &&
                                       (accepted_trace_id_q != expected_trace_id_i);
        end
    end

    logic [PM_CNT_W-1:0] near_acc_q;
    logic [PM_CNT_W-1:0] far_acc_q;
    logic                near_ds_q;
    logic                far_ds_q;
    logic                ssf_sec_q;
    logic [DEGRADE_WINDOW_COUNT_W-1:0]   bad_run_q;
    logic [DEGRADE_WINDOW_COUNT_W-1:0]   good_run_q;
    logic                degraded_defect_q;
    logic                bad_second;
    logic                uneq_zero;
    logic                tsf;
    logic                monitor_active;

    assign uneq_zero = unequipped_defect & (accepted_trace_id_q == TRACE_ZERO);
    assign tsf       = link_q.ssf | alarm_indication_defect | uneq_zero |
                       trace_mismatch_defect_q;
    assign monitor_active = (termination_point_mode_i == TPM_MON);
    assign bad_second     = (near_acc_q >= degrade_threshold_i);

    // per-second sums; events in the tick cycle are dropped, counted in neither interval
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            near_acc_q <= '0;
            far_acc_q  <= '0;
            near_ds_q  <= 1'b0;
            far_ds_q   <= 1'b0;
            ssf_sec_q  <= 1'b0;
        end else if (one_second_tick_i) begin
            near_acc_q <= '0;
            far_acc_q  <= '0;
            near_ds_q  <= 1'b0;
            far_ds_q   <= 1'b0;
            ssf_sec_q  <= 1'b0;
        end else begin
            if (near_err) begin
                near_acc_q <= sat_inc(near_acc_q);
            end
            if (far_err) begin
                far_acc_q <= sat_inc(far_acc_q);
            end
            near_ds_q <= near_ds_q | tsf | equipment_defect_i;
            far_ds_q  <= far_ds_q | remote_defect;
            ssf_sec_q <= ssf_sec_q | server_fail_condition;
        end
    end

    // present the closed interval for one cycle
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            pm_o       <= '0;
            pm_valid_o <= 1'b0;
        end else begin
            pm_valid_o <= one_second_tick_i;
            if (one_second_tick_i) begin
                pm_o.near_defect_second       <= near_ds_q;
                pm_o.far_defect_second        <= far_ds_q;
                pm_o.near_errored_block_count <= near_acc_q;
                pm_o.far_errored_block_count  <= far_acc_q;
            end
        end
    end

    // degrade: window of bad seconds sets, same run of good seconds clears;
    // seconds touched by server fail say nothing and leave the runs alone
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            bad_run_q         <= '0;
            good_run_q        <= '0;
            degraded_defect_q <= 1'b0;
        end else if (one_second_tick_i && !ssf_sec_q) begin
            if (bad_second) begin
                good_run_q <= '0;
                if (bad_run_q + 1'b1 >= degrade_window_count_i) begin
                    degraded_defect_q <= 1'b1;
                end else begin
                    bad_run_q <= bad_run_q + 1'b1;
                end
            end else begin
                bad_run_q <= '0;
                if (good_run_q + 1'b1 >= degrade_window_count_i) begin
                    degraded_defect_q <= 1'b0;
                end else begin
                    good_run_q <= good_run_q + 1'b1;
                end
            end
        end
    end

    // consequent actions and correlations, registered to the pins
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            trail_signal_fail_action_o    <= 1'b0;
            trail_signal_degrade_action_o <= 1'b0;
            report_o                      <= '0;
            accepted_trace_id_o           <= TRACE_RESET;
        end else begin
            trail_signal_fail_action_o    <= tsf;
            trail_signal_degrade_action_o <= degraded_defect_q;
            accepted_trace_id_o           <= accepted_trace_id_q;
            report_o.unequipped     <= monitor_active & uneq_zero;
            report_o.trace_mismatch <= monitor_active & trace_mismatch_defect_q &
                                       ~uneq_zero;
            report_o.degraded       <= monitor_active & degraded_defect_q &
                                       ~trace_mismatch_defect_q;
            report_o.remote_defect  <= monitor_active & remote_defect &
                                       remote_defect_report_enable_i &
                                       ~trace_mismatch_defect_q & ~uneq_zero;
            report_o.server_fail    <= monitor_active & server_fail_report_enable_i &
                                       server_fail_condition;
        end
    end
endmodule

// ===== vcm_mon_asserts.sv
`timescale 1ns/1ps
// port-level checker for the path monitor; single clock domain
module vcm_mon_asserts
    import vcm_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        reset_n_i,
    input wire logic        termination_point_mode_i,
    input wire logic        server_fail_report_enable_i,
    input wire logic        one_second_tick_i,
    input wire logic        trail_signal_fail_action_o,
    input wire logic        trail_signal_degrade_action_o,
    input vcm_pkg::vcm_report_s report_o,
    input wire logic [7:0]  accepted_trace_id_o,
    input wire logic        pm_valid_o,
    input wire logic        near_block_error_o,
    input wire logic        far_block_error_o
);
    import vcm_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    // three cycles out of monitor mode leave no report standing
    AST_MON_GATE: assert property (!termination_point_mode_i [*3] |-> report_o == '0)
        else $error("fault report while not monitored");
    AST_UNEQ_ZERO: assert property (report_o.unequipped |->
        (accepted_trace_id_o == TRACE_ZERO || $past(accepted_trace_id_o) == TRACE_ZERO))
        else $error("unequipped report with nonzero trace");
    AST_DEG_MASK: assert property (report_o.degraded |-> !report_o.trace_mismatch)
        else $error("degrade report beside trace mismatch");
    AST_RDI_MASK: assert property (report_o.remote_defect |->
        !report_o.trace_mismatch && !report_o.unequipped)
        else $error("remote defect report not masked");
    // enable may pass through one register, so two cycles of history are allowed
    AST_SSF_EN: assert property (report_o.server_fail |->
        $past(server_fail_report_enable_i) || $past(server_fail_report_enable_i, 2))
        else $error("server fail report without enable");
    AST_TSF: assert property (report_o.server_fail || report_o.trace_mismatch
        || report_o.unequipped |-> trail_signal_fail_action_o)
        else $error("trail fail missing");
    AST_TSD: assert property (report_o.degraded |-> trail_signal_degrade_action_o)
        else $error("trail degrade missing");
    AST_PM_VALID: assert property (one_second_tick_i |=> pm_valid_o)
        else $error("no figures after tick");
    AST_PM_ONLY: assert property (pm_valid_o |-> $past(one_second_tick_i))
        else $error("figures without tick");
    // errored frames are hundreds of cycles apart, so a pulse never lasts two cycles
    AST_BLK_PULSE: assert property (near_block_error_o || far_block_error_o |=>
        !near_block_error_o && !far_block_error_o)
        else $error("block error pulse too long");
    AST_RESET: assert property ($rose(reset_n_i) |-> accepted_trace_id_o == TRACE_RESET)
        else $error("trace not cleared by reset");
endmodule

bind vcm_path_monitor vcm_mon_asserts u_chk (
    .sys_clk_i                     (sys_clk_i),
    .reset_n_i                     (reset_n_i),
    .termination_point_mode_i      (termination_point_mode_i),
    .server_fail_report_enable_i   (server_fail_report_enable_i),
    .one_second_tick_i             (one_second_tick_i),
    .trail_signal_fail_action_o    (trail_signal_fail_action_o),
    .trail_signal_degrade_action_o (trail_signal_degrade_action_o),
    .report_o                      (report_o),
    .accepted_trace_id_o           (accepted_trace_id_o),
    .pm_valid_o                    (pm_valid_o),
    .near_block_error_o            (near_block_error_o),
    .far_block_error_o             (far_block_error_o)
);

// ===== vcm_src.sv
`timescale 1ns/1ps
// path source: byte clock runs only inside frames, data moves midway through the low phase
module vcm_src
    import vcm_pkg::*;
#(
    parameter int unsigned FB = 120
) (
    output logic       ci_clk_o,
    output logic [7:0] ci_data_o,
    output logic       ci_fs_o
);
    logic [1:0] bip_q;
    logic [3:0] k4_q;
    initial begin
        ci_clk_o = 1'b0;
        ci_data_o = 8'h00;
        ci_fs_o = 1'b0;
        bip_q = 2'h0;
        k4_q = 4'h0;
    end

    // one frame; bad flips the first parity bit sent for the previous frame
    task automatic send_frame(input logic [2:0] psl, input logic rei, input logic rdi,
                              input logic bad, input logic [7:0] j2);
        logic [7:0] b;
        logic [1:0] acc;
        acc = 2'h0;
        for (int i = 0; i < FB; i++) begin
            // byte bit 4 carries nothing here and is sent as zero
            if (i == 0) b = {bip_q ^ {bad, 1'b0}, rei, 1'b0, psl, rdi};
            else if (i == J2_POS) b = j2;
            else if (i == 3 * FB / 4) b = {4'h0, k4_q};
            else b = i[7:0] ^ 8'h5a;
            acc = acc ^ {b[7] ^ b[5] ^ b[3] ^ b[1], b[6] ^ b[4] ^ b[2] ^ b[0]};
            ci_fs_o = (i == 0);
            ci_data_o = b;
            #40 ci_clk_o = 1'b1;
            #80 ci_clk_o = 1'b0;
            // released line shows the inverse of the last byte; done at the clock fall
            // so a following frame's first byte lands in a later time step
            if (i == FB - 1) ci_data_o = ~b;
            #40;
        end
        bip_q = acc;
        k4_q = k4_q + 4'h1;
    endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
// self-checking bench; frames come from the path source model
module testbench;
    import vcm_pkg::*;
    localparam int unsigned FB = 120;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        ci_clk;
    logic [7:0]  ci_data;
    logic        ci_fs;
    logic        ssf = 1'b0;
    logic        mode = TPM_MON;
    logic        ssf_en = 1'b1;
    logic        rdi_en = 1'b1;
    logic        tim_dis = 1'b0;
    logic        tick = 1'b0;
    logic [7:0]  exp_id = 8'h3c;
    logic        cmp_mode = 1'b1;
    logic        eq_def = 1'b0;
    logic        tsf;
    logic        tsd;
    vcm_report_s rep;
    logic [7:0]  acc_id;
    vcm_pm_s     pm;
    logic        pm_valid;
    logic        near_err;
    logic        far_err;
    int          failures = 0;
    int          n_compared = 0;
    int          n_near = 0;
    int          n_far = 0;

    always #10 sys_clk = ~sys_clk;
    // count block error pulses, one per errored frame
    always @(posedge sys_clk) begin
        if (near_err === 1'b1) n_near++;
        if (far_err === 1'b1) n_far++;
    end

    vcm_src #(.FB(FB)) src (.ci_clk_o(ci_clk), .ci_data_o(ci_data), .ci_fs_o(ci_fs));
    // threshold and window of one make a single errored block a bad second
    vcm_path_monitor #(.FRAME_BYTES(FB)) dut (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .ci_clk_i(ci_clk),
        .ci_data_i(ci_data), .ci_fs_i(ci_fs), .incoming_server_signal_fail_i(ssf),
        .termination_point_mode_i(mode), .server_fail_report_enable_i(ssf_en),
        .remote_defect_report_enable_i(rdi_en), .expected_trace_id_i(exp_id),
        .expected_trace_compare_mode_i(cmp_mode), .trace_mismatch_disable_i(tim_dis),
        .degrade_threshold_i(16'h0001), .degrade_window_count_i(4'h1),
        .one_second_tick_i(tick), .equipment_defect_i(eq_def),
        .trail_signal_fail_action_o(tsf), .trail_signal_degrade_action_o(tsd),
        .report_o(rep), .accepted_trace_id_o(acc_id), .pm_o(pm), .pm_valid_o(pm_valid),
        .near_block_error_o(near_err), .far_block_error_o(far_err));

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic frames(input int n, input logic [2:0] psl, input logic rdi,
                          input logic [7:0] j2);
        repeat (n) src.send_frame(psl, 1'b0, rdi, 1'b0, j2);
    endtask
    // lets a level change pass the input synchronisers and output registers
    task automatic settle();
        repeat (8) @(posedge sys_clk);
        #2;
    endtask
    task automatic pulse_tick();
        @(posedge sys_clk);
        #2 tick = 1'b1;
        @(posedge sys_clk);
        #2 tick = 1'b0;
        chk(pm_valid, 1'b1);
    endtask

    task automatic t_trace();
        frames(4, 3'h2, 1'b0, 8'h3c);
        chk(acc_id, 8'h3c);
        chk(rep, 5'h00);
        chk(tsf, 1'b0);
        chk(n_near, 0);
        chk(n_far, 0);
    endtask
    task automatic t_errors();
        pulse_tick();
        src.send_frame(3'h2, 1'b1, 1'b0, 1'b1, 8'h3c);
        frames(1, 3'h2, 1'b0, 8'h3c);
        chk(n_near, 1);
        chk(n_far, 1);
        pulse_tick();
        chk(pm, {2'b00, 16'h0001, 16'h0001});
        repeat (2) @(posedge sys_clk);
        #2;
        chk(tsd, 1'b1);
        chk(rep, 5'h04);
        // an equipment defect alone must mark a near defect second
        eq_def = 1'b1;
        pulse_tick();
        eq_def = 1'b0;
        chk(pm, {2'b10, 32'h0});
        repeat (2) @(posedge sys_clk);
        #2;
        chk(tsd, 1'b0);
    endtask
    task automatic t_mismatch();
        exp_id = 8'h55;
        settle();
        chk(rep, 5'h08);
        chk(tsf, 1'b1);
        tim_dis = 1'b1;
        settle();
        chk(rep, 5'h00);
        tim_dis = 1'b0;
        cmp_mode = 1'b0;
        settle();
        chk(rep, 5'h00);
        cmp_mode = 1'b1;
        exp_id = 8'h3c;
        settle();
    endtask
    task automatic t_rdi();
        frames(5, 3'h2, 1'b1, 8'h3c);
        chk(rep, 5'h02);
        rdi_en = 1'b0;
        settle();
        chk(rep, 5'h00);
        rdi_en = 1'b1;
        pulse_tick();
        // the interval also held the mismatch, a trail fail
        chk(pm[33:32], 2'b11);
        frames(5, 3'h2, 1'b0, 8'h3c);
        chk(rep, 5'h00);
    endtask
    task automatic t_ais();
        frames(4, 3'h7, 1'b0, 8'h3c);
        chk(rep, 5'h00);
        frames(1, 3'h7, 1'b0, 8'h3c);
        chk(rep, 5'h01);
        chk(tsf, 1'b1);
        frames(4, 3'h2, 1'b0, 8'h3c);
        chk(rep, 5'h01);
        frames(1, 3'h2, 1'b0, 8'h3c);
        chk({rep, tsf}, 6'h00);
    endtask
    task automatic t_uneq();
        frames(5, 3'h0, 1'b0, 8'h00);
        chk(acc_id, 8'h00);
        chk(rep, 5'h10);
        chk(tsf, 1'b1);
        mode = 1'b0;
        settle();
        chk(rep, 5'h00);
        mode = TPM_MON;
        ssf = 1'b1;
        settle();
        chk(rep, 5'h01);
        ssf_en = 1'b0;
        settle();
        chk({rep, tsf}, 6'h01);
        ssf_en = 1'b1;
        ssf = 1'b0;
        pulse_tick();
        chk(pm[33], 1'b1);
    endtask

    task automatic results();
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // bounded run: a hang counts as a mismatch
    initial begin
        #1500000;
        failures++;
        results();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        #2 reset_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #2;
        t_trace();
        t_errors();
        t_mismatch();
        t_rdi();
        t_ais();
        t_uneq();
        results();
    end
endmodule
